//--- hdl/dmx_pkg.sv
package dmx_pkg;
	localparam logic [3:0]  OP_COPY_SRC   = 4'hC;
	localparam logic [3:0]  OP_COPY_DST   = 4'hF;
	localparam logic [5:0]  OP_MV_FILE    = 6'h14;
	localparam logic [7:0]  OP_BANK_LD    = 8'h01;
	localparam logic [9:0]  OP_PTR_HI     = 10'h3B8;
	localparam logic [7:0]  OP_PTR_LO     = 8'hF0;
	localparam logic [7:0]  ILO_LIMIT     = 8'h5F;
	localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
	localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
	localparam logic [11:0] WREG_ADDR     = 12'hFE8;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [11:0] RST_PTR       = 12'h000;
	localparam int          N_PTR         = 3;

	typedef enum logic [1:0] {
		DMX_IDLE     = 2'h0,
		DMX_PTR_LO   = 2'h1,
		DMX_COPY_DST = 2'h2
	} dmx_state_t;
endpackage : dmx_pkg

//--- hdl/dmx_exec.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// Behaviour
// (RULE_01) pointer load: high byte, then low byte
// (RULE_02) move file to accumulator or back; N,Z
// (RULE_03) file operand reaches whole 256-byte bank
// (RULE_04) access bit 0 access bank, 1 banked
// (RULE_05) extended set: f<=5Fh uses pointer-2 offset
// (RULE_06) file-to-file: two words, read then write
// (RULE_07) file-to-file spans full 4096-byte space
// (RULE_08) accumulator may be source or destination
// (RULE_09) software avoids pc-low and stack-top destinations
// (RULE_10) bank load literal, one cycle, flags kept
// (RULE_11) bank select upper nibble reads zero
// (RULE_12) only move-file touches status flags
module dmx_exec (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_instr_valid,
	input  wire logic [15:0] i_instr,
	input  wire logic        i_ext_en,
	input  wire logic [7:0]  i_mem_rd_data,
	output logic      [11:0] o_mem_rd_addr,
	output logic             o_mem_wr,
	output logic      [11:0] o_mem_wr_addr,
	output logic      [7:0]  o_mem_wr_data,
	output logic      [7:0]  o_wreg,
	output logic      [7:0]  o_bank_select_reg,
	output logic      [35:0] o_indirect_pointer_register,
	output logic             o_flag_n,
	output logic             o_flag_z,
	output logic             o_busy
);
	logic                 rst_meta;
	logic                 rst_sync_b;
	dmx_pkg::dmx_state_t  state;
	dmx_pkg::dmx_state_t  next_state;
	logic [11:0]          ptr [dmx_pkg::N_PTR];
	logic [11:0]          next_ptr [dmx_pkg::N_PTR];
	logic [1:0]           lsel;
	logic [1:0]           next_lsel;
	logic [7:0]           hold;
	logic [7:0]           next_hold;
	logic [7:0]           wreg;
	logic [7:0]           next_wreg;
	logic [7:0]           bank_sel;
	logic [7:0]           next_bank_sel;
	logic                 fn;
	logic                 next_fn;
	logic                 fz;
	logic                 next_fz;
	logic                 wr;
	logic                 next_wr;
	logic [11:0]          wr_addr;
	logic [11:0]          next_wr_addr;
	logic [7:0]           wr_data;
	logic [7:0]           next_wr_data;
	logic                 idle_v;
	logic                 is_ptr_ld;
	logic                 is_mv_file;
	logic                 is_copy;
	logic                 is_bank_ld;
	logic                 is_lo;
	logic                 is_dst;
	logic [7:0]           f_op;
	logic [11:0]          f_addr;
	logic [7:0]           rd_val;

	// reset is released synchronously so no flop leaves reset mid-edge
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_meta   <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	assign idle_v   = i_instr_valid && (state == dmx_pkg::DMX_IDLE);
	assign is_ptr_ld  = idle_v && (i_instr[15:6] == dmx_pkg::OP_PTR_HI)
		&& (i_instr[5:4] != 2'h3);
	assign is_mv_file = idle_v && (i_instr[15:10] == dmx_pkg::OP_MV_FILE);
	assign is_copy    = idle_v && (i_instr[15:12] == dmx_pkg::OP_COPY_SRC);
	assign is_bank_ld = idle_v && (i_instr[15:8] == dmx_pkg::OP_BANK_LD);
	assign is_lo      = i_instr_valid && (state == dmx_pkg::DMX_PTR_LO)
		&& (i_instr[15:8] == dmx_pkg::OP_PTR_LO);
	assign is_dst     = i_instr_valid && (state == dmx_pkg::DMX_COPY_DST)
		&& (i_instr[15:12] == dmx_pkg::OP_COPY_DST);
	assign f_op     = i_instr[7:0];

	// file operand to data address
	always_comb
	begin
		if (i_instr[8])
			f_addr = {bank_sel[3:0], f_op}; // RULE_03 RULE_04
		else if (i_ext_en && (f_op <= dmx_pkg::ILO_LIMIT))
			// offset wraps inside the 4 KB space, carry dropped on purpose
			f_addr = 12'(ptr[2] + {4'h0, f_op}); // RULE_05
		else if (f_op < dmx_pkg::ACCESS_SPLIT)
			f_addr = {4'h0, f_op}; // RULE_04
		else
			f_addr = {dmx_pkg::ACCESS_HI_BNK, f_op};
	end

	// source address: the full 12-bit field bypasses banking
	assign o_mem_rd_addr = is_copy ? i_instr[11:0] : f_addr; // RULE_07
	// accumulator is mapped into data space, served locally
	assign rd_val = (o_mem_rd_addr == dmx_pkg::WREG_ADDR) ? wreg
		: i_mem_rd_data; // RULE_08

	always_comb
	begin
		next_state   = state;
		next_ptr     = ptr;
		next_lsel    = lsel;
		next_hold    = hold;
		next_wreg    = wreg;
		next_bank_sel = bank_sel;
		next_fn      = fn; // RULE_12
		next_fz      = fz; // RULE_12
		next_wr      = 1'b0;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		case (state)
			dmx_pkg::DMX_IDLE:
			begin
				if (is_ptr_ld)
				begin
					next_lsel = i_instr[5:4];
					next_ptr[i_instr[5:4]][11:8] = i_instr[3:0]; // RULE_01
					next_state = dmx_pkg::DMX_PTR_LO;
				end
				else if (is_mv_file)
				begin
					next_fn = rd_val[7]; // RULE_02
					next_fz = (rd_val == 8'h00); // RULE_02
					if (!i_instr[9])
						next_wreg = rd_val; // RULE_02
					else if (f_addr != dmx_pkg::WREG_ADDR)
					begin
						next_wr      = 1'b1; // RULE_02
						next_wr_addr = f_addr;
						next_wr_data = rd_val;
					end
				end
				else if (is_copy)
				begin
					next_hold  = rd_val; // RULE_06
					next_state = dmx_pkg::DMX_COPY_DST;
				end
				else if (is_bank_ld)
					next_bank_sel = {4'h0, i_instr[3:0]}; // RULE_10 RULE_11
			end
			dmx_pkg::DMX_PTR_LO:
			begin
				if (is_lo)
					next_ptr[lsel][7:0] = i_instr[7:0]; // RULE_01
				if (i_instr_valid)
					next_state = dmx_pkg::DMX_IDLE;
			end
			dmx_pkg::DMX_COPY_DST:
			begin
				// RULE_09 pc-low and stack-top targets are not filtered here
				if (is_dst && (i_instr[11:0] == dmx_pkg::WREG_ADDR))
					next_wreg = hold; // RULE_08
				else if (is_dst)
				begin
					next_wr      = 1'b1; // RULE_06 RULE_07
					next_wr_addr = i_instr[11:0];
					next_wr_data = hold;
				end
				if (i_instr_valid)
					next_state = dmx_pkg::DMX_IDLE;
			end
			default:
				next_state = dmx_pkg::DMX_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			state   <= dmx_pkg::DMX_IDLE;
			for (int i = 0; i < dmx_pkg::N_PTR; i++)
				ptr[i] <= dmx_pkg::RST_PTR;
			lsel    <= 2'h0;
			hold    <= dmx_pkg::RST_BYTE;
			wreg    <= dmx_pkg::RST_BYTE;
			bank_sel <= dmx_pkg::RST_BYTE;
			fn      <= 1'b0;
			fz      <= 1'b0;
			wr      <= 1'b0;
			wr_addr <= dmx_pkg::RST_PTR;
			wr_data <= dmx_pkg::RST_BYTE;
		end
		else
		begin
			state   <= next_state;
			ptr     <= next_ptr;
			lsel    <= next_lsel;
			hold    <= next_hold;
			wreg    <= next_wreg;
			bank_sel <= next_bank_sel;
			fn      <= next_fn;
			fz      <= next_fz;
			wr      <= next_wr;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
		end
	end

	genvar g;
	generate
		for (g = 0; g < dmx_pkg::N_PTR; g++)
		begin : g_ptr
			assign o_indirect_pointer_register[g*12 +: 12] = ptr[g];
		end
	endgenerate

	assign o_mem_wr          = wr;
	assign o_mem_wr_addr     = wr_addr;
	assign o_mem_wr_data     = wr_data;
	assign o_wreg            = wreg;
	assign o_bank_select_reg = bank_sel;
	assign o_flag_n          = fn;
	assign o_flag_z          = fz;
	assign o_busy            = (state != dmx_pkg::DMX_IDLE);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_sync_b);

	property p_ptr_hi;
		is_ptr_ld |=> o_busy
			&& (ptr[$past(i_instr[5:4])][11:8] == $past(i_instr[3:0]));
	endproperty
	a_ptr_hi: assert property (p_ptr_hi) // RULE_01
		else $error("pointer high byte not loaded");

	property p_ptr_lo;
		is_lo |=> (ptr[$past(lsel)][7:0] == $past(i_instr[7:0])) && !o_busy;
	endproperty
	a_ptr_lo: assert property (p_ptr_lo) // RULE_01
		else $error("pointer low byte not loaded");

	property p_mv_w;
		(is_mv_file && !i_instr[9]) |=> (o_wreg == $past(rd_val))
			&& (o_flag_z == ($past(rd_val) == 8'h00))
			&& (o_flag_n == $past(rd_val[7]));
	endproperty
	a_mv_w: assert property (p_mv_w) // RULE_02
		else $error("move-file to accumulator wrong");

	property p_mv_f;
		(is_mv_file && i_instr[9] && (f_addr != dmx_pkg::WREG_ADDR))
			|=> o_mem_wr && (o_mem_wr_addr == $past(f_addr))
			&& (o_mem_wr_data == $past(rd_val)) && $stable(o_wreg);
	endproperty
	a_mv_f: assert property (p_mv_f) // RULE_02
		else $error("move-file write-back wrong");

	property p_banked;
		(is_mv_file && i_instr[8])
			|-> (o_mem_rd_addr == {bank_sel[3:0], f_op});
	endproperty
	a_banked: assert property (p_banked) // RULE_04
		else $error("banked address wrong");

	property p_ilo;
		(is_mv_file && !i_instr[8] && i_ext_en && (f_op <= 8'h5F))
			|-> (o_mem_rd_addr == 12'(ptr[2] + {4'h0, f_op}));
	endproperty
	a_ilo: assert property (p_ilo) // RULE_05
		else $error("indexed offset address wrong");

	property p_copy;
		is_copy ##1 (is_dst && (i_instr[11:0] != dmx_pkg::WREG_ADDR))
			|=> o_mem_wr && (o_mem_wr_data == $past(rd_val, 2))
			&& (o_mem_wr_addr == $past(i_instr[11:0]));
	endproperty
	a_copy: assert property (p_copy) // RULE_06
		else $error("file-to-file data lost");

	property p_copy_nowr;
		is_copy |=> !o_mem_wr && o_busy && $stable(o_flag_n)
			&& $stable(o_flag_z);
	endproperty
	a_copy_nowr: assert property (p_copy_nowr) // RULE_06
		else $error("file-to-file wrote early");

	property p_bank_ld;
		is_bank_ld |=> (o_bank_select_reg == {4'h0, $past(i_instr[3:0])})
			&& $stable(o_flag_n) && $stable(o_flag_z);
	endproperty
	a_bank_ld: assert property (p_bank_ld) // RULE_10
		else $error("bank load wrong");

	property p_bank_hi;
		o_bank_select_reg[7:4] == 4'h0;
	endproperty
	a_bank_hi: assert property (p_bank_hi) // RULE_11
		else $error("bank select upper nibble set");

	property p_flags;
		(i_instr_valid && !is_mv_file)
			|=> $stable(o_flag_n) && $stable(o_flag_z);
	endproperty
	a_flags: assert property (p_flags) // RULE_12
		else $error("flags changed");

	c_ptr_ld: cover property (is_ptr_ld ##1 is_lo);
	c_copy: cover property (is_copy ##1 is_dst);
	c_mv_wb: cover property (is_mv_file && i_instr[9]);
	c_ilo: cover property (is_mv_file && i_ext_en && !i_instr[8]);
endmodule : dmx_exec

//--- tb/dmx_exec_bench.sv
`timescale 1ns/1ps
module dmx_exec_bench;
	localparam logic [11:0] WA = dmx_pkg::WREG_ADDR;
	logic        i_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_instr_valid = 1'b0;
	logic [15:0] i_instr = 16'h0000;
	logic        i_ext_en = 1'b0;
	logic [7:0]  i_mem_rd_data;
	logic [11:0] o_mem_rd_addr, o_mem_wr_addr;
	logic        o_mem_wr, o_flag_n, o_flag_z, o_busy;
	logic [7:0]  o_mem_wr_data, o_wreg, o_bank_select_reg;
	logic [35:0] o_indirect_pointer_register;
	logic [7:0]  mem [4096];
	logic [7:0]  mdl [4096];
	logic [7:0]  w, b;
	logic [35:0] p;
	logic        n, z;
	logic [54:0] sq [$];
	logic [19:0] wq [$];
	int          bad_count = 0, tests_run = 0, cyc = 0, st_chk = 0;

	// forward a pending write so back-to-back reads see fresh data
	assign i_mem_rd_data = (o_mem_wr && o_mem_wr_addr == o_mem_rd_addr)
		? o_mem_wr_data : mem[o_mem_rd_addr];

	dmx_exec DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_instr_valid(i_instr_valid), .i_instr(i_instr),
		.i_ext_en(i_ext_en), .i_mem_rd_data(i_mem_rd_data),
		.o_mem_rd_addr(o_mem_rd_addr), .o_mem_wr(o_mem_wr),
		.o_mem_wr_addr(o_mem_wr_addr), .o_mem_wr_data(o_mem_wr_data),
		.o_wreg(o_wreg), .o_bank_select_reg(o_bank_select_reg),
		.o_indirect_pointer_register(o_indirect_pointer_register),
		.o_flag_n(o_flag_n), .o_flag_z(o_flag_z), .o_busy(o_busy));

	initial
	begin
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic check(string nm, logic [63:0] s, logic [63:0] e);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : check

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic send(logic [15:0] v);
		i_instr_valid <= 1'b1;
		i_instr       <= v;
		@(posedge i_clk);
	endtask : send

	task automatic idle(int k);
		i_instr_valid <= 1'b0;
		repeat (k) @(posedge i_clk);
	endtask : idle

	task automatic note(logic bz);
		sq.push_back({w, b, p, n, z, bz});
		st_chk++;
	endtask : note

	task automatic load_bank(logic [7:0] k);
		send({dmx_pkg::OP_BANK_LD, k});
		b = {4'h0, k[3:0]};
		note(1'b0);
	endtask : load_bank

	task automatic load_ptr(logic [1:0] s, logic [11:0] k, int gap);
		send({dmx_pkg::OP_PTR_HI, s, k[11:8]});
		p[12*s+8 +: 4] = k[11:8];
		note(1'b1);
		if (gap > 0)
			idle(gap);
		send({dmx_pkg::OP_PTR_LO, k[7:0]});
		p[12*s +: 8] = k[7:0];
		note(1'b0);
	endtask : load_ptr

	task automatic move_file(logic [7:0] f, logic d, logic a, logic x);
		logic [11:0] ad;
		logic [7:0]  v;
		i_ext_en <= x;
		if (a)
			ad = {b[3:0], f};
		else if (x && f <= dmx_pkg::ILO_LIMIT)
			ad = p[35:24] + {4'h0, f};
		else
			ad = (f < 8'h60) ? {4'h0, f} : {4'hF, f};
		v = (ad == WA) ? w : mdl[ad];
		send({dmx_pkg::OP_MV_FILE, d, a, f});
		{n, z} = {v[7], v == 8'h00};
		if (!d)
			w = v;
		else if (ad != WA)
			wq.push_back({ad, v});
		note(1'b0);
	endtask : move_file

	task automatic move_f2f(logic [11:0] s, logic [11:0] d);
		logic [7:0] v;
		v = (s == WA) ? w : mdl[s];
		send({dmx_pkg::OP_COPY_SRC, s});
		note(1'b1);
		send({dmx_pkg::OP_COPY_DST, d});
		if (d == WA)
			w = v;
		else
		begin
			mdl[d] = v;
			wq.push_back({d, v});
		end
		note(1'b0);
	endtask : move_f2f

	always @(posedge i_clk)
	begin
		if (o_mem_wr)
			mem[o_mem_wr_addr] <= o_mem_wr_data;
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			test_done();
		end
	end

	always @(negedge i_clk)
	begin
		if (st_chk > 0)
		begin
			st_chk--;
			check("state", {o_wreg, o_bank_select_reg,
				o_indirect_pointer_register, o_flag_n, o_flag_z, o_busy},
				sq.pop_front());
		end
		// any write, accumulator address included, must have been expected
		if (o_mem_wr)
			check("write", {o_mem_wr_addr, o_mem_wr_data},
				wq.size() ? wq.pop_front() : 'x);
	end

	initial
	begin
		logic [7:0] fl [6];
		void'($urandom(81793));
		for (int i = 0; i < 4096; i++)
		begin
			mem[i] = 8'($urandom());
			mdl[i] = mem[i];
		end
		{mem[0], mdl[0], mem[12'hF80], mdl[12'hF80]} = 32'h00008080;
		{w, b, p, n, z} = '0;
		fl = '{8'h00, 8'h5F, 8'h60, 8'hFF, 8'hE8, 8'($urandom())};
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1'b1;
		idle(3);
		note(1'b0);
		load_bank(8'hF5);
		load_bank(8'h0A);
		load_bank(8'($urandom()));
		$display("test bank load done");
		load_ptr(2'd0, 12'hFFF, 0);
		load_ptr(2'd1, 12'($urandom()), 2);
		load_ptr(2'd2, 12'h3AB, 0);
		$display("test pointer load done");
		for (int i = 0; i < 48; i++)
			move_file(fl[i / 8], i[0], i[1], i[2]);
		move_file(8'h80, 1'b0, 1'b0, 1'b0);
		$display("test move file done");
		// destinations stay plain data bytes, except one copy into the accumulator
		for (int i = 0; i < 6; i++)
			move_f2f(12'($urandom()), 12'($urandom_range(0, 12'hEFF)));
		move_f2f(WA, 12'h000);
		move_f2f(12'hFFF, WA);
		move_f2f(12'h000, 12'h123);
		load_bank(8'h3C);
		load_ptr(2'd1, 12'h800, 1);
		$display("test file to file done");
		idle(3);
		check("pending", sq.size() + wq.size(), 0);
		test_done();
	end
endmodule : dmx_exec_bench
